// *** rtl/bflt_pkg.sv ***
/*
 package for the boot undervoltage and overcurrent fault logic.
 assumes a 20 mhz system clock; all times are given in ns and converted here.
*/
package bflt_pkg;
	localparam int CLK_PERIOD_NS = 50;
	// tri-state hold time for recovery, refresh and current-report restart
	localparam int TRI_HOLD_NS = 19000;
	localparam int TRI_HOLD_CYC = TRI_HOLD_NS / CLK_PERIOD_NS;
	// current report restart delay
	localparam int REPORT_DELAY_NS = 1000;
	localparam int REPORT_DELAY_CYC = REPORT_DELAY_NS / CLK_PERIOD_NS;
	// shutdown hold-off time in tri-state window (value not printed)
	localparam int SHDN_HOLD_NS = 200;
	localparam int SHDN_HOLD_CYC = (SHDN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 10;
	localparam logic [TMR_W-1:0] TMR_ZERO = 10'h000;
	localparam logic [TMR_W-1:0] TMR_ONE = 10'h001;
	localparam logic [TMR_W-1:0] TRI_HOLD_T = TMR_W'(TRI_HOLD_CYC);
	localparam logic [TMR_W-1:0] REPORT_DELAY_T = TMR_W'(REPORT_DELAY_CYC);
	localparam logic [TMR_W-1:0] SHDN_HOLD_T = TMR_W'(SHDN_HOLD_CYC);
	// boot fault counter
	localparam logic [1:0] BOOT_CNT_ZERO = 2'h0;
	localparam logic [1:0] BOOT_CNT_ONE = 2'h1;
	localparam logic [1:0] BOOT_CNT_LOCK = 2'h3;
	// overcurrent truncation counter
	localparam logic [3:0] OC_CNT_ZERO = 4'h0;
	localparam logic [3:0] OC_CNT_ONE = 4'h1;
	localparam logic [3:0] OC_CNT_FAULT = 4'ha;
	// decoded three-level pwm input
	typedef enum logic [1:0] {
		BFLT_PWM_LOW = 2'b00,
		BFLT_PWM_HIGH = 2'b01,
		BFLT_PWM_TRI = 2'b10
	} bflt_pwm_t;
endpackage

// *** rtl/bflt_fault_logic.sv ***
/*
 fault logic of a power-stage gate driver: boot undervoltage lockout,
 boot refresh, current report gating and overcurrent fault latch.
 assumes pwm already decoded to three levels and analog comparators
 delivered as digital levels synchronous to clk.
*/
// Contract
// (RQ1) check boot only after both supplies good
// (RQ2) low gate follows pwm, high waits boot
// (RQ3) boot error set at startup, below falling
// (RQ4) boot error clears above rising threshold
// (RQ5) flagged falling pwm edge increments counter
// (RQ6) count three latches both gates off
// (RQ7) tri-state hold clears counter, restarts startup
// (RQ8) unflagged falling edge clears boot counter
// (RQ9) refresh after tri-state hold if boot low
// (RQ10) refresh ends at rising threshold or exit
// (RQ11) supply power cycle also clears lockout
// (RQ12) controller shuts down after boot lockout; the controller model parks only on temp_fault_output, not on lockout
// (RQ13) report current only during switch on-time
// (RQ14) long tri-state delays current report restart
// (RQ15) overcurrent trip truncates active duty cycle
// (RQ16) count consecutive truncations, reset otherwise
// (RQ17) ten truncations drive fault output high
// (RQ18) controller treats fault high as shutdown
// (RQ19) fault latched until supply power cycle
// (RQ20) tri-state hold-off suspends switching, gates low
// (RQ21) decoded pwm, digital comparators, local timers
`timescale 1ns/1ps
module bflt_fault_logic (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// supplies and comparators
	input wire logic logic_supply_ok,
	input wire logic gate_drive_supply_ok,
	input wire logic boot_above_rising,
	input wire logic boot_below_falling,
	input wire logic overcurrent_trip,
	// pwm from controller
	input wire bflt_pkg::bflt_pwm_t pwm,
	// gate outputs
	output logic high_side_gate,
	output logic low_side_gate,
	output logic gates_tristate,
	// status outputs
	output logic boot_undervoltage,
	output logic boot_refresh,
	output logic current_report_enable,
	output logic temp_fault_output
);
	import bflt_pkg::*;

	logic supplies_ok;
	logic power_cycle;
	logic gate_allow;
	logic tri_clear;
	logic boot_step;
	logic boot_clear;
	logic oc_step;
	logic oc_clear;
	bflt_pwm_t pwm_reg;
	logic falling_edge;
	logic high_enable_reg;
	logic boot_err_reg;
	logic [1:0] boot_cnt_reg;
	logic lockout_reg;
	logic [TMR_W-1:0] tri_tmr_reg;
	logic tri_long;
	logic shdn;
	logic long_tri_seen_reg;
	logic [TMR_W-1:0] rpt_tmr_reg;
	logic truncating_reg;
	logic [3:0] oc_cnt_reg;
	logic fault_reg;
	logic duty_end;

	////////////////////////////////////////////////////////////////////////
	// supply and pwm tracking

	assign supplies_ok = logic_supply_ok && gate_drive_supply_ok;
	// a loss of either supply is a power cycle for the latches
	assign power_cycle = !supplies_ok; // [RQ11] [RQ19]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm_reg <= BFLT_PWM_TRI;
		end else begin
			pwm_reg <= pwm;
		end
	end

	// high to low or high to tri-state
	assign falling_edge = (pwm_reg == BFLT_PWM_HIGH) && (pwm != BFLT_PWM_HIGH);

	// tri-state duration timer, saturating so a long park never wraps short
	assign tri_clear = (pwm != BFLT_PWM_TRI) || !supplies_ok;

	bflt_sat_cnt #(
		.W(TMR_W)
	) u_tri_tmr (
		.clk(clk),
		.rst(rst),
		.clear(tri_clear),
		.step(1'b1), // [RQ21]
		.limit(TRI_HOLD_T),
		.count(tri_tmr_reg)
	);

	assign tri_long = (tri_tmr_reg == TRI_HOLD_T);
	assign shdn = (pwm == BFLT_PWM_TRI) && (tri_tmr_reg >= SHDN_HOLD_T); // [RQ20]

	////////////////////////////////////////////////////////////////////////
	// boot error flag and lockout

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_err_reg <= 1'b1;
		end else if (!supplies_ok) begin
			boot_err_reg <= 1'b1; // [RQ3] [RQ1]
		end else if (boot_below_falling) begin
			// set wins if both comparators claim at once
			boot_err_reg <= 1'b1; // [RQ3]
		end else if (boot_above_rising) begin
			boot_err_reg <= 1'b0; // [RQ4]
		end
	end

	// high side released once boot first clears rising threshold
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			high_enable_reg <= 1'b0;
		end else if (!supplies_ok || lockout_reg) begin
			high_enable_reg <= 1'b0; // [RQ2]
		end else if (boot_above_rising && !boot_below_falling) begin
			high_enable_reg <= 1'b1; // [RQ2]
		end
	end

	// a flagged falling edge steps, an unflagged one starts the run again
	assign boot_step = falling_edge && !lockout_reg && boot_err_reg; // [RQ5]
	assign boot_clear = power_cycle || tri_long || // [RQ7] [RQ11]
		(falling_edge && !lockout_reg && !boot_err_reg); // [RQ8]

	bflt_sat_cnt #(
		.W($bits(boot_cnt_reg))
	) u_boot_cnt (
		.clk(clk),
		.rst(rst),
		.clear(boot_clear),
		.step(boot_step),
		.limit(BOOT_CNT_LOCK),
		.count(boot_cnt_reg)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lockout_reg <= 1'b0;
		end else if (power_cycle || tri_long) begin
			lockout_reg <= 1'b0; // [RQ7] [RQ11]
		end else if (boot_cnt_reg == BOOT_CNT_LOCK) begin
			lockout_reg <= 1'b1; // [RQ6]
		end
	end

	// refresh after long tri-state while boot is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_refresh <= 1'b0;
		end else if (!supplies_ok || pwm != BFLT_PWM_TRI || boot_above_rising) begin
			boot_refresh <= 1'b0; // [RQ10]
		end else if (tri_long && boot_below_falling) begin
			boot_refresh <= 1'b1; // [RQ9]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// overcurrent truncation and fault latch

	// a duty cycle ends at the falling edge of pwm
	assign duty_end = falling_edge;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			truncating_reg <= 1'b0;
		end else if (pwm != BFLT_PWM_HIGH) begin
			truncating_reg <= 1'b0;
		end else if (overcurrent_trip) begin
			truncating_reg <= 1'b1; // [RQ15]
		end
	end

	// counter holds at the fault value until a supply drops or a duty cycle ends untruncated
	assign oc_step = duty_end && truncating_reg; // [RQ16]
	assign oc_clear = power_cycle || (duty_end && !truncating_reg); // [RQ16]

	bflt_sat_cnt #(
		.W($bits(oc_cnt_reg))
	) u_oc_cnt (
		.clk(clk),
		.rst(rst),
		.clear(oc_clear),
		.step(oc_step),
		.limit(OC_CNT_FAULT),
		.count(oc_cnt_reg)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_reg <= 1'b0;
		end else if (oc_cnt_reg == OC_CNT_FAULT && supplies_ok) begin
			fault_reg <= 1'b1; // [RQ17]
		end else if (power_cycle) begin
			fault_reg <= 1'b0; // [RQ19]
		end
	end

	assign temp_fault_output = fault_reg;

	////////////////////////////////////////////////////////////////////////
	// current report gating

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			long_tri_seen_reg <= 1'b0;
			rpt_tmr_reg <= TMR_ZERO;
		end else if (pwm == BFLT_PWM_TRI) begin
			if (tri_long) begin
				long_tri_seen_reg <= 1'b1;
			end
			rpt_tmr_reg <= TMR_ZERO;
		end else if (long_tri_seen_reg) begin
			// restart delay runs only after a long tri-state
			if (rpt_tmr_reg == REPORT_DELAY_T - TMR_ONE) begin
				long_tri_seen_reg <= 1'b0; // [RQ14]
			end else begin
				rpt_tmr_reg <= rpt_tmr_reg + TMR_ONE; // [RQ14]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gate drive outputs, registered

	// one permission for both gates: lockout forces both off whatever pwm does
	assign gate_allow = supplies_ok && !lockout_reg && !shdn;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gates_tristate <= 1'b1;
		end else begin
			// same-cycle supply term keeps this flag in step with the gates
			gates_tristate <= lockout_reg || !supplies_ok; // [RQ6]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			high_side_gate <= 1'b0;
			low_side_gate <= 1'b0;
		end else begin
			high_side_gate <= gate_allow && high_enable_reg && (pwm == BFLT_PWM_HIGH) &&
				!overcurrent_trip; // [RQ2] [RQ15] [RQ20]
			low_side_gate <= gate_allow && (pwm == BFLT_PWM_LOW); // [RQ2] [RQ20]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_undervoltage <= 1'b1;
		end else begin
			boot_undervoltage <= boot_err_reg; // [RQ3]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			current_report_enable <= 1'b0;
		end else begin
			current_report_enable <= supplies_ok && !lockout_reg && (pwm != BFLT_PWM_TRI) &&
				!long_tri_seen_reg; // [RQ13] [RQ14]
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////
// saturating event counter shared by the timer and both fault counters

module bflt_sat_cnt #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control, clear wins over step
	input wire logic clear,
	input wire logic step,
	input wire logic [W-1:0] limit,
	// running count
	output logic [W-1:0] count
);
	import bflt_pkg::*;

	localparam logic [W-1:0] CNT_ZERO = '0;
	localparam logic [W-1:0] CNT_ONE = W'(1);

	// holding at the limit keeps a long event from wrapping back to a short one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= CNT_ZERO;
		end else if (clear) begin
			count <= CNT_ZERO;
		end else if (step && count != limit) begin
			count <= count + CNT_ONE;
		end
	end

endmodule

// *** dv/bflt_props.sv ***
/* port checker for bflt_fault_logic; one clk domain, async high rst */
`timescale 1ns/1ps
module bflt_props
	import bflt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// design inputs
	input wire logic logic_supply_ok,
	input wire logic gate_drive_supply_ok,
	input wire logic boot_above_rising,
	input wire logic boot_below_falling,
	input wire logic overcurrent_trip,
	input wire bflt_pkg::bflt_pwm_t pwm,
	// design outputs
	input wire logic high_side_gate,
	input wire logic low_side_gate,
	input wire logic gates_tristate,
	input wire logic boot_undervoltage,
	input wire logic boot_refresh,
	input wire logic current_report_enable,
	input wire logic temp_fault_output
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire off = !high_side_gate && !low_side_gate;
	wire tri_in = pwm == BFLT_PWM_TRI;
	wire ok = logic_supply_ok && gate_drive_supply_ok;
	a_tri_gates_off: assert property (tri_in |=> off) else $error("gate on in tri");
	a_lock_gates_off: assert property (gates_tristate |-> off) else $error("gate on in lock");
	a_high_needs_pwm: assert property (high_side_gate |-> $past(pwm) == BFLT_PWM_HIGH) else $error("high gate");
	a_oc_cuts_duty: assert property (overcurrent_trip |=> !high_side_gate) else $error("duty not cut");
	a_tri_report_zero: assert property (tri_in |=> !current_report_enable) else $error("report in tri");
	a_fault_stays: assert property (temp_fault_output && ok |=> temp_fault_output) else $error("fault lost");
	a_refresh_ends: assert property (boot_above_rising || !tri_in |=> !boot_refresh) else $error("refresh");
	a_boot_flag_set: assert property (boot_below_falling |-> ##2 boot_undervoltage) else $error("boot flag");
	c_lockout: cover property (gates_tristate);
	c_refresh: cover property (boot_refresh);
	c_fault: cover property (temp_fault_output);
endmodule
bind bflt_fault_logic bflt_props u_props (
	.clk(clk),
	.rst(rst),
	.logic_supply_ok(logic_supply_ok),
	.gate_drive_supply_ok(gate_drive_supply_ok),
	.boot_above_rising(boot_above_rising),
	.boot_below_falling(boot_below_falling),
	.overcurrent_trip(overcurrent_trip),
	.pwm(pwm),
	.high_side_gate(high_side_gate),
	.low_side_gate(low_side_gate),
	.gates_tristate(gates_tristate),
	.boot_undervoltage(boot_undervoltage),
	.boot_refresh(boot_refresh),
	.current_report_enable(current_report_enable),
	.temp_fault_output(temp_fault_output)
);

// *** dv/bflt_ctrl_model.sv ***
/* pwm controller model; parks pwm in tri-state on reset or a fault demand */
`timescale 1ns/1ps
module bflt_ctrl_model
	import bflt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fault demand from the driver
	input wire logic fault,
	// wanted level and level on the pin
	input wire bflt_pkg::bflt_pwm_t want,
	output bflt_pkg::bflt_pwm_t pwm
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm <= BFLT_PWM_TRI;
		end else begin
			pwm <= fault ? BFLT_PWM_TRI : want;
		end
	end
endmodule

// *** dv/tb_boot_uvlo_and_overcurrent_fault_logic.sv ***
/* bench for bflt_fault_logic and controller model; 20 mhz clk, full timers */
`timescale 1ns/1ps
module tb_boot_uvlo_and_overcurrent_fault_logic;
	import bflt_pkg::*;
	logic clk = 1'h0, rst = 1'h1, logic_supply_ok = 1'h1, gate_drive_supply_ok = 1'h1, overcurrent_trip = 1'h0;
	logic boot_above_rising = 1'h0, boot_below_falling = 1'h1, high_side_gate, low_side_gate, gates_tristate;
	logic boot_undervoltage, boot_refresh, current_report_enable, temp_fault_output;
	bflt_pwm_t pwm, want = BFLT_PWM_TRI;
	int n_errors = 0, checks_done = 0, k;
	logic [31:0] seed = 32'h549b7abf;
	bflt_fault_logic dut (
		.clk(clk),
		.rst(rst),
		.logic_supply_ok(logic_supply_ok),
		.gate_drive_supply_ok(gate_drive_supply_ok),
		.boot_above_rising(boot_above_rising),
		.boot_below_falling(boot_below_falling),
		.overcurrent_trip(overcurrent_trip),
		.pwm(pwm),
		.high_side_gate(high_side_gate),
		.low_side_gate(low_side_gate),
		.gates_tristate(gates_tristate),
		.boot_undervoltage(boot_undervoltage),
		.boot_refresh(boot_refresh),
		.current_report_enable(current_report_enable),
		.temp_fault_output(temp_fault_output)
	);
	bflt_ctrl_model ctrl (.clk, .rst, .fault(temp_fault_output), .want, .pwm);
	initial forever #25 clk = ~clk;
	initial begin
		repeat (2000) @(posedge clk);
		n_errors++;
		test_done();
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic exp_fault(input int n);
		return n >= 10;
	endfunction
	task automatic chk(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pcyc(input logic trip, input logic hi);
		@(posedge clk);
		want <= BFLT_PWM_HIGH;
		overcurrent_trip <= trip;
		repeat (3) @(posedge clk);
		want <= BFLT_PWM_LOW;
		overcurrent_trip <= 1'h0;
		#1;
		chk("high_gate", hi && !trip, high_side_gate);
		repeat (3) @(posedge clk);
		#1;
		chk("low_gate", 1'h1, low_side_gate);
	endtask
	task automatic test_done;
		if (n_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		want <= BFLT_PWM_LOW;
		pcyc(1'h0, 1'h0);
		pcyc(1'h0, 1'h0);
		boot_below_falling <= 1'h0;
		boot_above_rising <= 1'h1;
		pcyc(1'h0, 1'h1);
		boot_below_falling <= 1'h1;
		boot_above_rising <= 1'h0;
		pcyc(1'h0, 1'h1);
		pcyc(1'h0, 1'h1);
		tick(1);
		chk("lockout", 1'h0, gates_tristate);
		pcyc(1'h0, 1'h1);
		tick(1);
		chk("lockout", 1'h1, gates_tristate);
		@(posedge clk);
		want <= BFLT_PWM_TRI;
		tick(400);
		chk("lockout", 1'h0, gates_tristate);
		chk("refresh", 1'h1, boot_refresh);
		@(posedge clk);
		boot_below_falling <= 1'h0;
		boot_above_rising <= 1'h1;
		want <= BFLT_PWM_LOW;
		tick(10);
		chk("boot_uv", 1'h0, boot_undervoltage);
		chk("report", 1'h0, current_report_enable);
		tick(20);
		chk("report", 1'h1, current_report_enable);
		repeat (3) begin
			seed = xs(seed);
			k = 1 + int'(seed % 9);
			repeat (k) pcyc(1'h1, 1'h1);
			pcyc(1'h0, 1'h1);
			chk("fault", exp_fault(k), temp_fault_output);
		end
		repeat (10) pcyc(1'h1, 1'h1);
		chk("fault", exp_fault(10), temp_fault_output);
		tick(50);
		chk("fault", 1'h1, temp_fault_output);
		@(posedge clk);
		gate_drive_supply_ok <= 1'h0;
		repeat (3) @(posedge clk);
		gate_drive_supply_ok <= 1'h1;
		tick(3);
		chk("fault", 1'h0, temp_fault_output);
		@(posedge clk);
		boot_below_falling <= 1'h1;
		boot_above_rising <= 1'h0;
		repeat (3) pcyc(1'h0, 1'h1);
		tick(1);
		chk("lockout", 1'h1, gates_tristate);
		@(posedge clk);
		logic_supply_ok <= 1'h0;
		@(posedge clk);
		logic_supply_ok <= 1'h1;
		tick(2);
		chk("lockout", 1'h0, gates_tristate);
		test_done();
	end
endmodule
